// ===== verilog/medc_defs.vh
/*
 constants for the motion event detect configuration block: register
 offsets, write masks, field positions, reset values and counts.
 assumes inclusion by its bare name from the design file.
*/
// Notes on behaviour
// - orientation bit 7 selects four-direction, no Z
// - bits 6:5 pick 80/70/60/50 degree angle
// - offset-source bit picks low-pass corrected wake data
// - six-bit wake threshold, reset zero
// - weight bit: full scale over 2^6 or 2^8
// - wake duration in output data periods
// - sleep LSB 512 periods, zero means 16
// - six-bit free-fall duration split over two registers
// - free-fall threshold 156 to 500 mg
// - bit 7 routes activity events to first pin
// - bit 5 routes wake-up events to first pin
// - bit 4 routes free-fall events to first pin
// - bit 2 routes orientation events to first pin
// - activity shows pulse or level by mode bit
// - mode bit zero: change pulse; one: status level
// - latch bit holds pulse requests until cleared
// - global enable needed for all detectors
`ifndef MEDC_DEFS_VH
`define MEDC_DEFS_VH

// register offsets
`define MEDC_ADDR_ORIENT   8'h59
`define MEDC_ADDR_WAKEUP_THRESHOLD   8'h5B
`define MEDC_ADDR_WK_DUR   8'h5C
`define MEDC_ADDR_FF       8'h5D
`define MEDC_ADDR_MD1      8'h5E
`define MEDC_ADDR_MD2      8'h5F
`define MEDC_ADDR_STATUS   8'h1D

// writable bits, reserved bits stay zero
`define MEDC_MASK_ORIENT   8'hE0
`define MEDC_MASK_WAKEUP_THRESHOLD   8'h7F
`define MEDC_MASK_WK_DUR   8'hFF
`define MEDC_MASK_FF       8'hFF
`define MEDC_MASK_MD1      8'hB4
`define MEDC_MASK_MD2      8'hB5
`define MEDC_REG_RESET     8'h00

// field positions
`define MEDC_FOUR_DIR_BIT  7
`define MEDC_ANGLE_HI      6
`define MEDC_ANGLE_LO      5
`define MEDC_OFFSRC_BIT    6
`define MEDC_WAKEUP_THRESHOLD_HI     5
`define MEDC_WAKEUP_THRESHOLD_LO     0
`define MEDC_FF_MSB_BIT    7
`define MEDC_WK_DUR_HI     6
`define MEDC_WK_DUR_LO     5
`define MEDC_THS_W_BIT     4
`define MEDC_SLP_DUR_HI    3
`define MEDC_SLP_DUR_LO    0
`define MEDC_FREEFALL_DURATION_HI     7
`define MEDC_FREEFALL_DURATION_LO     3
`define MEDC_FREEFALL_THRESHOLD_HI     2
`define MEDC_FREEFALL_THRESHOLD_LO     0
`define MEDC_RT_ACT_BIT    7
`define MEDC_RT_WU_BIT     5
`define MEDC_RT_FF_BIT     4
`define MEDC_RT_OR_BIT     2

// timing counts in output data periods
`define MEDC_SLEEP_LSB_ODR 14'h0200
`define MEDC_SLEEP_ZERO_ODR 14'h0010

`endif

// ===== verilog/medc_top.v
/*
 motion event detector configuration, detectors and first-pin routing.
 assumes all inputs come from logic on i_clk, i_odr_tick pulses once
 per output data period, magnitudes are already computed upstream.
*/
`timescale 1ns/1ps
`include "medc_defs.vh"

module medc_top (
    input  wire        i_clk,            // 250 MHz core clock
    input  wire        i_reset,          // async, active high
    input  wire        i_reg_wr,         // register write strobe
    input  wire        i_reg_rd,         // register read strobe
    input  wire [7:0]  i_reg_addr,       // register offset
    input  wire [7:0]  i_reg_wdata,      // write data
    output reg  [7:0]  o_reg_rdata,      // read data, registered
    input  wire        i_functions_enable, // global detector enable
    input  wire        i_interrupt_latch,  // hold pin requests
    input  wire        i_sleep_status_on_pin, // level vs pulse
    input  wire        i_int_clear,      // clears latched request
    input  wire        i_odr_tick,       // one output data period
    input  wire [7:0]  i_wake_hp_mag,    // high-pass, fs/2^8 units
    input  wire [7:0]  i_wake_lp_mag,    // low-pass offset corrected
    input  wire [9:0]  i_accel_mag_mg,   // total magnitude in mg
    input  wire [2:0]  i_orient_pos,     // 0..5: +x -x +y -y +z -z
    input  wire [6:0]  i_tilt_angle_deg, // tilt from horizontal
    output reg         o_wakeup_event,   // one-cycle pulse
    output reg         o_freefall_event, // one-cycle pulse
    output reg         o_orient_event,   // one-cycle pulse
    output reg         o_sleep_change,   // one-cycle pulse
    output reg         o_sleep_state,    // level
    output reg         o_first_interrupt_pin // active high
);

    // configuration registers
    reg [7:0]  orient_q;                 // four-dir and angle
    reg [7:0]  wkths_q;                  // wake threshold
    reg [7:0]  wkdur_q;                  // durations and weight
    reg [7:0]  ff_q;                     // free-fall setup
    reg [7:0]  md1_q;                    // first pin routing
    reg [7:0]  md2_q;                    // second pin routing, stored
    reg [7:0]  rdata_d;                  // read mux

    // detector state
    reg [2:0]  wk_cnt_q;                 // wake persistence count
    reg [6:0]  ff_cnt_q;                 // free-fall persistence
    reg [13:0] slp_cnt_q;                // inactivity count
    reg [2:0]  last_pos_q;               // last reported position
    reg        hold_q;                   // latched pin request

    // decoded fields
    wire       four_dir_enable;
    wire [1:0] orientation_angle_sel;
    wire       wakeup_offset_source;
    wire [5:0] wakeup_threshold;
    wire       ths_weight;
    wire [1:0] wakeup_duration;
    wire [3:0] sleep_entry_duration;
    wire [5:0] freefall_duration;
    wire [2:0] freefall_threshold;

    assign four_dir_enable       = orient_q[`MEDC_FOUR_DIR_BIT];
    assign orientation_angle_sel =
        orient_q[`MEDC_ANGLE_HI:`MEDC_ANGLE_LO];
    assign wakeup_offset_source  = wkths_q[`MEDC_OFFSRC_BIT];
    assign wakeup_threshold      =
        wkths_q[`MEDC_WAKEUP_THRESHOLD_HI:`MEDC_WAKEUP_THRESHOLD_LO];
    assign ths_weight            = wkdur_q[`MEDC_THS_W_BIT];
    assign wakeup_duration       =
        wkdur_q[`MEDC_WK_DUR_HI:`MEDC_WK_DUR_LO];
    assign sleep_entry_duration  =
        wkdur_q[`MEDC_SLP_DUR_HI:`MEDC_SLP_DUR_LO];
    // msb from duration register, rest from free-fall register
    assign freefall_duration     = {wkdur_q[`MEDC_FF_MSB_BIT],
        ff_q[`MEDC_FREEFALL_DURATION_HI:`MEDC_FREEFALL_DURATION_LO]};
    assign freefall_threshold    =
        ff_q[`MEDC_FREEFALL_THRESHOLD_HI:`MEDC_FREEFALL_THRESHOLD_LO];

    // register writes, reserved bits masked to zero
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            orient_q <= `MEDC_REG_RESET;
            wkths_q  <= `MEDC_REG_RESET;
            wkdur_q  <= `MEDC_REG_RESET;
            ff_q     <= `MEDC_REG_RESET;
            md1_q    <= `MEDC_REG_RESET;
            md2_q    <= `MEDC_REG_RESET;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `MEDC_ADDR_ORIENT: begin
                    orient_q <= i_reg_wdata & `MEDC_MASK_ORIENT;
                end
                `MEDC_ADDR_WAKEUP_THRESHOLD: begin
                    wkths_q <= i_reg_wdata & `MEDC_MASK_WAKEUP_THRESHOLD;
                end
                `MEDC_ADDR_WK_DUR: begin
                    wkdur_q <= i_reg_wdata & `MEDC_MASK_WK_DUR;
                end
                `MEDC_ADDR_FF: begin
                    ff_q <= i_reg_wdata & `MEDC_MASK_FF;
                end
                `MEDC_ADDR_MD1: begin
                    md1_q <= i_reg_wdata & `MEDC_MASK_MD1;
                end
                `MEDC_ADDR_MD2: begin
                    md2_q <= i_reg_wdata & `MEDC_MASK_MD2;
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
    end

    // read mux, unmapped offsets read zero
    always @* begin
        case (i_reg_addr)
            `MEDC_ADDR_ORIENT: rdata_d = orient_q;
            `MEDC_ADDR_WAKEUP_THRESHOLD: rdata_d = wkths_q;
            `MEDC_ADDR_WK_DUR: rdata_d = wkdur_q;
            `MEDC_ADDR_FF:     rdata_d = ff_q;
            `MEDC_ADDR_MD1:    rdata_d = md1_q;
            `MEDC_ADDR_MD2:    rdata_d = md2_q;
            `MEDC_ADDR_STATUS: rdata_d = {4'h0, hold_q, o_sleep_state,
                                          last_pos_q[1:0] ^ 2'h0};
            default:           rdata_d = 8'h00;
        endcase
    end

    // read data registered on the read strobe
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rdata_d;
        end
    end

    // wake-up threshold scaled to fs/2^8 units
    wire [7:0] wakeup_threshold_eff;
    assign wakeup_threshold_eff = ths_weight ?
        {2'b00, wakeup_threshold} :        // fs/2^8 per lsb
        {wakeup_threshold, 2'b00};         // fs/2^6 per lsb

    // source selection for the wake detector
    wire [7:0] wk_mag;
    assign wk_mag = wakeup_offset_source ?
        i_wake_lp_mag : i_wake_hp_mag;

    // wake condition: magnitude above threshold
    wire wk_cond;
    assign wk_cond = (wk_mag > wakeup_threshold_eff);

    // free-fall threshold table in mg
    reg [9:0] freefall_threshold_mg;
    always @* begin
        case (freefall_threshold)
            3'h0:    freefall_threshold_mg = 10'h09C;   // 156 mg
            3'h1:    freefall_threshold_mg = 10'h0DB;   // 219 mg
            3'h2:    freefall_threshold_mg = 10'h0FA;   // 250 mg
            3'h3:    freefall_threshold_mg = 10'h138;   // 312 mg
            3'h4:    freefall_threshold_mg = 10'h158;   // 344 mg
            3'h5:    freefall_threshold_mg = 10'h196;   // 406 mg
            3'h6:    freefall_threshold_mg = 10'h1D5;   // 469 mg
            default: freefall_threshold_mg = 10'h1F4;   // 500 mg
        endcase
    end

    // free-fall condition: magnitude below threshold
    wire ff_cond;
    assign ff_cond = (i_accel_mag_mg < freefall_threshold_mg);

    // orientation angle table in degrees
    reg [6:0] or_ths_deg;
    always @* begin
        case (orientation_angle_sel)
            2'h0:    or_ths_deg = 7'h50;    // 80 degrees
            2'h1:    or_ths_deg = 7'h46;    // 70 degrees
            2'h2:    or_ths_deg = 7'h3C;    // 60 degrees
            default: or_ths_deg = 7'h32;    // 50 degrees
        endcase
    end

    // position usable: z positions dropped in four-direction mode
    wire pos_valid;
    assign pos_valid = (i_orient_pos < 3'h4) ||
        (!four_dir_enable && i_orient_pos < 3'h6);

    // sleep entry target in output data periods
    wire [13:0] slp_target;
    assign slp_target = (sleep_entry_duration == 4'h0) ?
        `MEDC_SLEEP_ZERO_ODR :
        (`MEDC_SLEEP_LSB_ODR *
         {10'h000, sleep_entry_duration});

    // wake-up persistence counter, fires once per episode
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wk_cnt_q       <= 3'h0;
            o_wakeup_event <= 1'b0;
        end else begin
            o_wakeup_event <= 1'b0;
            if (!i_functions_enable) begin
                wk_cnt_q <= 3'h0;
            end else if (i_odr_tick) begin
                if (!wk_cond) begin
                    wk_cnt_q <= 3'h0;        // lapse restarts
                end else begin
                    if (wk_cnt_q == {1'b0, wakeup_duration}) begin
                        o_wakeup_event <= 1'b1;
                    end
                    if (wk_cnt_q <= {1'b0, wakeup_duration}) begin
                        wk_cnt_q <= wk_cnt_q + 3'h1;
                    end
                end
            end
        end
    end

    // free-fall persistence counter, fires once per episode
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ff_cnt_q         <= 7'h00;
            o_freefall_event <= 1'b0;
        end else begin
            o_freefall_event <= 1'b0;
            if (!i_functions_enable) begin
                ff_cnt_q <= 7'h00;
            end else if (i_odr_tick) begin
                if (!ff_cond) begin
                    ff_cnt_q <= 7'h00;
                end else begin
                    if (ff_cnt_q == {1'b0, freefall_duration}) begin
                        o_freefall_event <= 1'b1;
                    end
                    if (ff_cnt_q <= {1'b0, freefall_duration}) begin
                        ff_cnt_q <= ff_cnt_q + 7'h01;
                    end
                end
            end
        end
    end

    // orientation change detector, one check per data period
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            last_pos_q     <= 3'h0;
            o_orient_event <= 1'b0;
        end else begin
            o_orient_event <= 1'b0;
            if (i_functions_enable && i_odr_tick && pos_valid &&
                i_tilt_angle_deg >= or_ths_deg &&
                i_orient_pos != last_pos_q) begin
                last_pos_q     <= i_orient_pos;
                o_orient_event <= 1'b1;
            end
        end
    end

    // activity/inactivity: quiet periods lead to sleep
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            slp_cnt_q      <= 14'h0000;
            o_sleep_state  <= 1'b0;
            o_sleep_change <= 1'b0;
        end else begin
            o_sleep_change <= 1'b0;
            if (!i_functions_enable) begin
                slp_cnt_q     <= 14'h0000;
                o_sleep_state <= 1'b0;
            end else if (i_odr_tick) begin
                if (wk_cond) begin
                    slp_cnt_q <= 14'h0000;   // activity restarts
                    if (o_sleep_state) begin
                        o_sleep_state  <= 1'b0;
                        o_sleep_change <= 1'b1;
                    end
                end else if (!o_sleep_state) begin
                    if (slp_cnt_q + 14'h0001 >= slp_target) begin
                        o_sleep_state  <= 1'b1;
                        o_sleep_change <= 1'b1;
                        slp_cnt_q      <= 14'h0000;
                    end else begin
                        slp_cnt_q <= slp_cnt_q + 14'h0001;
                    end
                end
            end
        end
    end

    // routed event requests for the first pin
    wire act_route;
    wire pulse_req;
    wire level_req;
    assign act_route = md1_q[`MEDC_RT_ACT_BIT];
    assign pulse_req =
        (md1_q[`MEDC_RT_WU_BIT] & o_wakeup_event) |
        (md1_q[`MEDC_RT_FF_BIT] & o_freefall_event) |
        (md1_q[`MEDC_RT_OR_BIT] & o_orient_event) |
        (act_route & !i_sleep_status_on_pin &
         o_sleep_change);
    assign level_req = act_route & i_sleep_status_on_pin &
        o_sleep_state;

    // latch holds pulses until cleared, new request beats clear
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hold_q <= 1'b0;
        end else if (!i_interrupt_latch) begin
            hold_q <= 1'b0;                  // not held
        end else if (pulse_req) begin
            hold_q <= 1'b1;                  // set wins
        end else if (i_int_clear) begin
            hold_q <= 1'b0;
        end
    end

    // pin driven from a flop
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_first_interrupt_pin <= 1'b0;
        end else begin
            o_first_interrupt_pin <= pulse_req | level_req |
                (hold_q & !i_int_clear);
        end
    end

endmodule // medc_top

// ===== test/medc_properties.sv
/*
 port checker for medc_top: detector pulses, pin cause and release, latch, reads.
 assumes binding to medc_top, one clock, reset async and active high.
*/
`timescale 1ns/1ps
module medc_properties (
    input wire       i_clk,
    input wire       i_reset,
    input wire       i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] o_reg_rdata,
    input wire       i_functions_enable,
    input wire       i_interrupt_latch,
    input wire       i_int_clear,
    input wire       i_odr_tick,
    input wire       o_wakeup_event,
    input wire       o_freefall_event,
    input wire       o_orient_event,
    input wire       o_sleep_change,
    input wire       o_sleep_state,
    input wire       o_first_interrupt_pin
);
    // tick the detectors may act on
    wire       tick_en = i_odr_tick & i_functions_enable;
    // anything that may raise the pin
    wire       cause   = o_wakeup_event | o_freefall_event |
                         o_orient_event | o_sleep_change | o_sleep_state;
    // reserved bits of the addressed register
    wire [7:0] rsv     = (i_reg_addr == 8'h59) ? 8'h1F :
                         (i_reg_addr == 8'h5B) ? 8'h80 :
                         (i_reg_addr == 8'h5E) ? 8'h4B :
                         (i_reg_addr == 8'h5F) ? 8'h4A : 8'h00;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // nothing pending and no latching
    sequence s_quiet;
        !i_interrupt_latch && !cause;
    endsequence
    // pin raised by a wake pulse while latching
    sequence s_latched_rise;
        $rose(o_first_interrupt_pin) && $past(o_wakeup_event) &&
        $past(i_interrupt_latch) && i_interrupt_latch && !i_int_clear;
    endsequence

    a_wake_on_tick: assert property (
        o_wakeup_event |-> $past(tick_en))
        else $error("wake pulse without enabled tick");
    a_fall_on_tick: assert property (
        o_freefall_event |-> $past(tick_en))
        else $error("free-fall pulse without enabled tick");
    a_orient_on_tick: assert property (
        o_orient_event |-> $past(tick_en))
        else $error("orientation pulse without enabled tick");
    a_wake_fires_once: assert property (
        o_wakeup_event |=> !o_wakeup_event)
        else $error("wake pulse longer than one cycle");
    a_sleep_edge_pulse: assert property (
        $changed(o_sleep_state) && $past(i_functions_enable)
        |-> o_sleep_change)
        else $error("sleep state moved without change pulse");
    a_sleep_off_disabled: assert property (
        !i_functions_enable |=> !o_sleep_state)
        else $error("sleep state kept while disabled");
    a_pin_has_cause: assert property (
        $rose(o_first_interrupt_pin) |-> $past(cause))
        else $error("pin rose with no event");
    a_pin_drops: assert property (
        s_quiet ##1 s_quiet |=> !o_first_interrupt_pin)
        else $error("pin held without latching");
    a_latch_holds: assert property (
        s_latched_rise |=> o_first_interrupt_pin)
        else $error("latched request not held");
    a_reserved_zero: assert property (
        i_reg_rd |=> (o_reg_rdata & $past(rsv)) == 8'h00)
        else $error("reserved bit read back as one");
endmodule // medc_properties

bind medc_top medc_properties u_props (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
    .i_functions_enable(i_functions_enable),
    .i_interrupt_latch(i_interrupt_latch), .i_int_clear(i_int_clear),
    .i_odr_tick(i_odr_tick), .o_wakeup_event(o_wakeup_event),
    .o_freefall_event(o_freefall_event), .o_orient_event(o_orient_event),
    .o_sleep_change(o_sleep_change), .o_sleep_state(o_sleep_state),
    .o_first_interrupt_pin(o_first_interrupt_pin)
);

// ===== test/medc_host_model.sv
/*
 host-side model: watches the first interrupt pin and acknowledges a
 held request when told to. assumes one clock, async high reset.
*/
`timescale 1ns/1ps
module medc_host_model (
    input  wire i_clk,       // core clock
    input  wire i_reset,     // async, active high
    input  wire i_pin,       // first interrupt pin
    input  wire i_auto_ack,  // acknowledge enable
    output reg  o_int_clear  // clear pulse to device
);
    // one-cycle acknowledge after the pin is seen high
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_int_clear <= 1'h0;
        end else begin
            o_int_clear <= i_auto_ack & i_pin & ~o_int_clear;
        end
    end
endmodule // medc_host_model

// ===== test/medc_top_tb.sv
/*
 testbench for medc_top: register access, detectors, routing, latch.
 assumes medc_defs.vh on the include path and the host model beside it.
*/
`timescale 1ns/1ps
`include "medc_defs.vh"
module medc_top_tb;
    reg        clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0;
    reg        fen = 1'h0, lat = 1'h0, stp = 1'h0, tick = 1'h0;
    reg        ack = 1'h0;
    reg  [7:0] addr = 8'h00, wdat = 8'h00, hp = 8'h00, lp = 8'h00;
    reg  [9:0] mg = 10'h3E8;                  // well above any fall level
    reg  [2:0] pos = 3'h0;
    reg  [6:0] tilt = 7'h00;
    wire [7:0] rdat;
    wire       wev, fev, oev, sch, sst, pin, clr;
    reg  [7:0] ad [0:6], mk [0:6];            // offsets and writable bits
    reg  [9:0] ffmg [0:7];                    // fall levels in mg
    reg  [6:0] ang [0:3];                     // angle per code
    reg  [3:0] ev;
    integer    fails = 0, check_count = 0, cyc = 0, i;

    medc_top dut (
        .i_clk(clk), .i_reset(rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdat),
        .i_functions_enable(fen), .i_interrupt_latch(lat),
        .i_sleep_status_on_pin(stp), .i_int_clear(clr),
        .i_odr_tick(tick), .i_wake_hp_mag(hp), .i_wake_lp_mag(lp),
        .i_accel_mag_mg(mg), .i_orient_pos(pos), .i_tilt_angle_deg(tilt),
        .o_wakeup_event(wev), .o_freefall_event(fev),
        .o_orient_event(oev), .o_sleep_change(sch), .o_sleep_state(sst),
        .o_first_interrupt_pin(pin)
    );
    medc_host_model host (.i_clk(clk), .i_reset(rst), .i_pin(pin),
        .i_auto_ack(ack), .o_int_clear(clr));

    // free-running clock
    initial begin
        forever #2 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 8000) begin
            fails = fails + 1;
            close_out;
        end
    end

    task chk(input [15:0] s, input [15:0] e); begin
        check_count = check_count + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    end endtask
    // one write; callers keep reserved bits zero unless probing them
    task wreg(input [7:0] a, input [7:0] d); begin
        @(posedge clk); wr <= 1'h1; addr <= a; wdat <= d;
        @(posedge clk); wr <= 1'h0;
    end endtask
    task rreg(input [7:0] a, input [7:0] e); begin
        @(posedge clk); rd <= 1'h1; addr <= a;
        @(posedge clk); rd <= 1'h0;
        @(negedge clk) chk(rdat, e);
        @(posedge clk);
    end endtask
    // one data period, then the four pulses {wake,fall,orient,sleep}
    task odr(input [3:0] e); begin
        @(posedge clk); tick <= 1'h1;
        @(posedge clk); tick <= 1'h0;
        @(negedge clk) ev = {wev, fev, oev, sch};
        chk(ev, e);
        @(posedge clk);
    end endtask
    // pin as set at the last rising edge, ends on the next one
    task pchk(input e); begin
        @(negedge clk) chk(pin, e);
        @(posedge clk);
    end endtask
    task close_out; begin
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    end endtask

    initial begin
        ad[0] = 8'h59; ad[1] = 8'h5B; ad[2] = 8'h5C; ad[3] = 8'h5D;
        ad[4] = 8'h5E; ad[5] = 8'h5F; ad[6] = 8'h5A;  // last is unmapped
        mk[0] = 8'hE0; mk[1] = 8'h7F; mk[2] = 8'hFF; mk[3] = 8'hFF;
        mk[4] = 8'hB4; mk[5] = 8'hB5; mk[6] = 8'h00;
        ffmg[0] = 10'h09C; ffmg[1] = 10'h0DB; ffmg[2] = 10'h0FA;
        ffmg[3] = 10'h138; ffmg[4] = 10'h158; ffmg[5] = 10'h196;
        ffmg[6] = 10'h1D5; ffmg[7] = 10'h1F4;
        ang[0] = 7'h50; ang[1] = 7'h46; ang[2] = 7'h3C; ang[3] = 7'h32;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        // reset values, then writable bits only
        for (i = 0; i < 7; i = i + 1) rreg(ad[i], 8'h00);
        for (i = 0; i < 7; i = i + 1) begin
            wreg(ad[i], 8'hFF);
            rreg(ad[i], mk[i]);
            wreg(ad[i], 8'h00);
        end
        fen <= 1'h1;
        // wake: threshold 2 -> 8 fine steps, duration 2, long sleep
        wreg(8'h5E, 8'h20); wreg(8'h5B, 8'h02); wreg(8'h5C, 8'h4F);
        hp <= 8'h09;
        odr(4'h0); odr(4'h0); odr(4'h8);
        pchk(1'h1);
        hp <= 8'h08; odr(4'h0);
        hp <= 8'h09; odr(4'h0); odr(4'h0); odr(4'h8);
        wreg(8'h5C, 8'h1F); hp <= 8'h02; odr(4'h0);
        hp <= 8'h03; odr(4'h8);
        hp <= 8'h00; odr(4'h0);
        wreg(8'h5B, 8'h42); lp <= 8'h09; odr(4'h8);
        lp <= 8'h00; odr(4'h0);
        fen <= 1'h0; lp <= 8'h09; odr(4'h0);
        fen <= 1'h1; lp <= 8'h00;
        // free-fall: every level, strict compare, duration 0
        wreg(8'h5E, 8'h10); wreg(8'h5C, 8'h0F);
        for (i = 0; i < 8; i = i + 1) begin
            wreg(8'h5D, {5'h00, i[2:0]});
            mg <= ffmg[i]; odr(4'h0);
            mg <= ffmg[i] - 10'h001; odr(4'h4);
        end
        // six-bit duration 33 across both registers
        wreg(8'h5C, 8'h8F); wreg(8'h5D, 8'h0F);
        mg <= 10'h1F4; odr(4'h0);
        mg <= 10'h064;
        for (i = 0; i < 33; i = i + 1) odr(4'h0);
        odr(4'h4);
        pchk(1'h1);
        // orientation: each angle code, one degree short then exact
        wreg(8'h5E, 8'h04); mg <= 10'h3E8;
        for (i = 0; i < 4; i = i + 1) begin
            wreg(8'h59, {1'h0, i[1:0], 5'h00});
            pos <= i[2:0] + 3'h1; tilt <= ang[i] - 7'h01;
            odr(4'h0);
            tilt <= ang[i]; odr(4'h2);
        end
        pchk(1'h1);
        wreg(8'h59, 8'h80); pos <= 3'h5; tilt <= 7'h50;
        odr(4'h0);
        wreg(8'h59, 8'h00); odr(4'h2);
        // sleep, status level on the pin, default 16 periods
        tilt <= 7'h00;
        wreg(8'h5E, 8'h80); wreg(8'h5C, 8'h00); stp <= 1'h1; fen <= 1'h0;
        @(posedge clk); fen <= 1'h1;
        for (i = 0; i < 15; i = i + 1) odr(4'h0);
        odr(4'h1);
        pchk(1'h1);
        repeat (5) @(posedge clk);
        pchk(1'h1);
        lp <= 8'h09; odr(4'h9);
        // sleep, change pulse on the pin, 512 periods
        lp <= 8'h00; stp <= 1'h0;
        @(negedge clk) chk(sst, 1'h0);
        wreg(8'h5C, 8'h01); fen <= 1'h0;
        @(posedge clk); fen <= 1'h1;
        for (i = 0; i < 511; i = i + 1) odr(4'h0);
        odr(4'h1);
        pchk(1'h1);
        pchk(1'h0);
        // latched wake request, held until the host acknowledges
        wreg(8'h5E, 8'h20); lat <= 1'h1; lp <= 8'h09;
        odr(4'h9);
        pchk(1'h1);
        repeat (6) @(posedge clk);
        rreg(8'h1D, 8'h09);
        pchk(1'h1);
        ack <= 1'h1;
        repeat (4) @(posedge clk);
        @(negedge clk) chk(pin, 1'h0);
        close_out;
    end
endmodule // medc_top_tb
